// ---- verilog/radio_core_sleep_wake_diag.sv ----
// Contract
// - In deep sleep timekeeping runs on the sleep clock, keeping the 625 us slot.
// - Deep sleep ends only on timer expiry or a software wake request.
// - Wake interrupt rises a configured number of sleep-clock cycles before wake time.
// - Expired timer waits for power; reported duration includes the extra time.
// - Exit and sleep-exit interrupt only with timer expired or wake request taken, clocks on, power up.
// - Setting the wake request in any state but ST_IDLE raises the wake interrupt at once, width from field.
// - Sleep entry is refused while the wake request bit stays high.
// - The external-wake disable bit makes the core ignore the wake request.
// - Eight diagnostic output ports are provided.
// - Signal scheme maps radio enables, sync, event and interrupt pulses to ports.
// - Data scheme maps receive and transmit data bits with qualifiers to ports.
// - Sync-found pulse appears only when correlation succeeds inside the sync window.
// - Error pulse when core and processor hit the same memory in one cycle.
// - Event pulse at the end of every event.
// - Wake-assert offset counts sleep-clock cycles before expiry for the rising edge.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module radio_core_sleep_wake_diag
  import sleep_wake_pkg::*;
#(
  parameter int SLOT_REF_CYCLES = SLOT_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              sleep_clock,
  input  wire logic              domain_up_flag,
  output logic                   radio_clk_enable,
  output logic                   baseband_power_down,
  output logic                   powerdown_allowed_flag,
  output logic                   lp_wake_interrupt,
  output logic                   sleep_exit_interrupt,
  input  wire logic              radio_tx_en,
  input  wire logic              radio_rx_en,
  input  wire logic              sync_window,
  input  wire logic              corr_success,
  input  wire logic              event_in_process,
  input  wire logic              rx_packet_irq,
  input  wire logic              core_mem_req,
  input  wire logic [MEM_AW-1:0] core_mem_addr,
  input  wire logic              cpu_mem_req,
  input  wire logic [MEM_AW-1:0] cpu_mem_addr,
  input  wire logic [7:0]        data_bits,
  output logic      [7:0]        diag_out
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0]       wake_timing_q;
  logic [31:0]       sleep_dur_q;
  logic [31:0]       ctrl_q;
  logic [31:0]       act_dur_q;
  logic [31:0]       sel_a_q;
  logic [31:0]       sel_b_q;
  logic [31:0]       sel_c_q;
  logic [31:0]       rdata_q;
  logic [31:0]       elapsed_q;
  logic [OFS_W-1:0]  ext_cnt_q;
  logic              ext_active_q;
  logic              wake_eff_q;
  logic              lp_wake_q;
  logic              exit_q;
  logic              pd_q;
  logic [SLOT_W-1:0] slot_div_q;
  logic [SLOT_W-1:0] slot_cnt_q;
  sleep_state_t      state_q;
  sleep_state_t      state_d;
  logic [1:0]        sync_lvl;
  logic [1:0]        sync_rise;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  sleep_wake_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     ({domain_up_flag, sleep_clock}),
    .level   (sync_lvl),
    .rise    (sync_rise)
  );

  wire lp_tick = sync_rise[0];
  wire dom_up  = sync_lvl[1];

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_timing = reg_wr && (reg_addr == REG_WAKE_TIMING);
  wire wr_dur    = reg_wr && (reg_addr == REG_SLEEP_DUR);
  wire wr_ctrl   = reg_wr && (reg_addr == REG_DS_CTRL);
  wire wr_sel_a  = reg_wr && (reg_addr == REG_DIAG_A);
  wire wr_sel_b  = reg_wr && (reg_addr == REG_DIAG_B);
  wire wr_sel_c  = reg_wr && (reg_addr == REG_DIAG_C);

  wire [OFS_W-1:0] assert_off   = wake_timing_q[ASSERT_LSB +: OFS_W];
  wire [OFS_W-1:0] deassert_off = wake_timing_q[DEASSERT_LSB +: OFS_W];
  wire [OFS_W-1:0] ext_width    = wake_timing_q[EXTW_LSB +: OFS_W];
  wire [31:0]      assert32     = 32'(assert_off);
  wire [31:0]      deassert32   = 32'(deassert_off);

  wire sleep_req = ctrl_q[CTL_SLEEP_REQ];
  wire ext_dis   = ctrl_q[CTL_EXT_DIS];
  wire wake_req  = ctrl_q[CTL_WAKE_REQ];
  wire clk_en    = ctrl_q[CTL_CLK_EN];

  // ---------------------------------------------------------------
  // Sleep timer decisions
  // ---------------------------------------------------------------
  wire wake_eff  = wake_req && !ext_dis;
  wire ext_start = wake_eff && !wake_eff_q && (state_q != ST_IDLE);
  wire expire_now = (state_q == ST_SLEEP) && (elapsed_q >= sleep_dur_q);
  wire [31:0] rem = sleep_dur_q - elapsed_q;
  wire sched_win = (state_q == ST_SLEEP) && !expire_now &&
                   (rem <= assert32) && (rem > deassert32);
  wire exit_now  = (state_q == ST_EXPIRED) && clk_en && dom_up;
  wire in_sleep  = (state_q == ST_SLEEP) || (state_q == ST_EXPIRED);

  // Hold time past the deassert offset; never below one sleep-clock period
  wire [OFS_W-1:0] ext_hold = (ext_width > deassert_off) ? OFS_W'(ext_width - deassert_off) : OFS_W'(1);
  wire [OFS_W-1:0] ext_cnt_inc = OFS_W'(ext_cnt_q + OFS_W'(1));
  wire ext_done = ext_active_q && lp_tick && (ext_cnt_inc >= ext_hold);
  wire ext_active_d = ext_start || (ext_active_q && !ext_done);
  wire [OFS_W-1:0] ext_cnt_d = ext_start ? '0 : ((ext_active_q && lp_tick) ? ext_cnt_inc : ext_cnt_q);

  // Counting carries on past expiry so the reported duration grows
  wire [31:0] elapsed_d = (state_q == ST_ENTER) ? 32'h0000_0000 :
                          ((lp_tick && in_sleep) ? 32'(elapsed_q + 32'h0000_0001) : elapsed_q);

  // Software write wins over the hardware clear of the sleep request
  wire [31:0] ctrl_d = wr_ctrl ? reg_wdata : (exit_now ? (ctrl_q & ~CTRL_REQ_MASK) : ctrl_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (sleep_req && !wake_eff) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (ext_start) begin
          state_d = ST_EXPIRED;
        end else if (lp_tick) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ext_start || expire_now) begin
          state_d = ST_EXPIRED;
        end
      end
      ST_EXPIRED: begin
        if (exit_now) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Slot reference
  // ---------------------------------------------------------------
  // Sleep rate rounds the slot down to whole sleep-clock ticks
  wire on_lp     = (state_q != ST_IDLE);
  wire slot_step = on_lp ? lp_tick : 1'b1;
  wire [SLOT_W-1:0] slot_lim = on_lp ? SLOT_W'(SLOT_LP_TICKS - 1) : SLOT_W'(SLOT_REF_CYCLES - 1);
  wire slot_wrap = slot_step && (slot_div_q >= slot_lim);
  wire [SLOT_W-1:0] slot_div_d = slot_wrap ? '0 : (slot_step ? SLOT_W'(slot_div_q + SLOT_W'(1)) : slot_div_q);
  wire [SLOT_W-1:0] slot_cnt_d = slot_wrap ? SLOT_W'(slot_cnt_q + SLOT_W'(1)) : slot_cnt_q;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [31:0] status_w = {27'h0000000, (state_q == ST_EXPIRED), lp_wake_q, in_sleep, dom_up, pd_q};
  wire [31:0] rd_mux =
      (reg_addr == REG_WAKE_TIMING) ? wake_timing_q :
      (reg_addr == REG_SLEEP_DUR)   ? sleep_dur_q :
      (reg_addr == REG_DS_CTRL)     ? ctrl_q :
      (reg_addr == REG_STATUS)      ? status_w :
      (reg_addr == REG_ACT_DUR)     ? act_dur_q :
      (reg_addr == REG_DIAG_A)      ? sel_a_q :
      (reg_addr == REG_DIAG_B)      ? sel_b_q :
      (reg_addr == REG_DIAG_C)      ? sel_c_q :
      (reg_addr == REG_SLOT_CNT)    ? 32'(slot_cnt_q) : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Flops
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_timing_q <= WAKE_TIMING_RST;
      sleep_dur_q   <= SLEEP_DUR_RST;
      ctrl_q        <= CTRL_RST;
      sel_a_q       <= DIAG_SEL_RST;
      sel_b_q       <= DIAG_SEL_RST;
      sel_c_q       <= DIAG_SEL_RST;
      rdata_q       <= 32'h0000_0000;
    end else begin
      if (wr_timing) wake_timing_q <= reg_wdata;
      if (wr_dur)    sleep_dur_q   <= reg_wdata;
      if (wr_sel_a)  sel_a_q       <= reg_wdata;
      if (wr_sel_b)  sel_b_q       <= reg_wdata;
      if (wr_sel_c)  sel_c_q       <= reg_wdata;
      ctrl_q  <= ctrl_d;
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q      <= ST_IDLE;
      elapsed_q    <= 32'h0000_0000;
      act_dur_q    <= 32'h0000_0000;
      ext_cnt_q    <= '0;
      ext_active_q <= 1'b0;
      wake_eff_q   <= 1'b0;
      lp_wake_q    <= 1'b0;
      exit_q       <= 1'b0;
      pd_q         <= 1'b0;
      slot_div_q   <= '0;
      slot_cnt_q   <= '0;
    end else begin
      state_q      <= state_d;
      elapsed_q    <= elapsed_d;
      ext_cnt_q    <= ext_cnt_d;
      ext_active_q <= ext_active_d;
      wake_eff_q   <= wake_eff;
      lp_wake_q    <= sched_win || ext_active_d;
      exit_q       <= exit_now;
      pd_q         <= (state_d == ST_SLEEP) || (state_d == ST_EXPIRED);
      slot_div_q   <= slot_div_d;
      slot_cnt_q   <= slot_cnt_d;
      if (exit_now) act_dur_q <= elapsed_q;
    end
  end

  // ---------------------------------------------------------------
  // Diagnostics
  // ---------------------------------------------------------------
  diag_if dg ();

  assign dg.sel_a            = sel_a_q;
  assign dg.sel_b            = sel_b_q;
  assign dg.sel_c            = sel_c_q;
  assign dg.tx_en            = radio_tx_en;
  assign dg.rx_en            = radio_rx_en;
  assign dg.sync_window      = sync_window;
  assign dg.corr_success     = corr_success;
  assign dg.event_in_process = event_in_process;
  assign dg.rx_irq           = rx_packet_irq;
  assign dg.core_mem_req     = core_mem_req;
  assign dg.cpu_mem_req      = cpu_mem_req;
  assign dg.core_mem_addr    = core_mem_addr;
  assign dg.cpu_mem_addr     = cpu_mem_addr;
  assign dg.data_sig         = data_bits;

  diag_mux u_diag (
    .ref_clk (ref_clk),
    .srst    (srst),
    .bus     (dg.mux)
  );

  assign diag_out               = dg.diag_out;
  assign reg_rdata              = rdata_q;
  assign radio_clk_enable       = ctrl_q[CTL_CLK_EN];
  assign baseband_power_down    = ctrl_q[CTL_PWR_DN];
  assign powerdown_allowed_flag = pd_q;
  assign lp_wake_interrupt      = lp_wake_q;
  assign sleep_exit_interrupt   = exit_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_entry_tick;
    (state_q == ST_ENTER) && lp_tick && !ext_start;
  endsequence

  sequence s_wake_due;
    (state_q == ST_SLEEP) && lp_tick && !ext_start && (assert_off > deassert_off) && (rem == assert32 + 32'h1);
  endsequence

  property p_entry_refused;
    @(posedge ref_clk) disable iff (srst) ((state_q == ST_IDLE) && wake_eff) |=> (state_q == ST_IDLE);
  endproperty
  a_entry_refused: assert property (p_entry_refused) else $error("sleep entered under wake request");

  property p_pd_after_tick;
    @(posedge ref_clk) disable iff (srst) s_entry_tick |=> (powerdown_allowed_flag && (state_q == ST_SLEEP));
  endproperty
  a_pd_after_tick: assert property (p_pd_after_tick) else $error("powerdown flag late");

  property p_sched_wake;
    @(posedge ref_clk) disable iff (srst) s_wake_due |=> ##1 lp_wake_interrupt;
  endproperty
  a_sched_wake: assert property (p_sched_wake) else $error("scheduled wake interrupt missing");

  property p_ext_immediate;
    @(posedge ref_clk) disable iff (srst) ext_start |=> (lp_wake_interrupt && (state_q == ST_EXPIRED));
  endproperty
  a_ext_immediate: assert property (p_ext_immediate) else $error("external wake not immediate");

  property p_ext_ignored;
    @(posedge ref_clk) disable iff (srst)
      ((state_q == ST_SLEEP) && ext_dis && wake_req && !expire_now) |=> (state_q == ST_SLEEP);
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("disabled wake request acted on");

  property p_exit_cause;
    @(posedge ref_clk) disable iff (srst)
      $rose(sleep_exit_interrupt) |-> $past(state_q == ST_EXPIRED && clk_en && dom_up) ##1 !sleep_exit_interrupt;
  endproperty
  a_exit_cause: assert property (p_exit_cause) else $error("sleep exit without cause");

  property p_exit_duration;
    @(posedge ref_clk) disable iff (srst)
      (exit_now && !ext_active_q && (elapsed_q >= sleep_dur_q)) |=> (act_dur_q >= sleep_dur_q);
  endproperty
  a_exit_duration: assert property (p_exit_duration) else $error("reported duration short");

  property p_wait_power;
    @(posedge ref_clk) disable iff (srst)
      ((state_q == ST_EXPIRED) && !dom_up) |=> ((state_q == ST_EXPIRED) && !sleep_exit_interrupt);
  endproperty
  a_wait_power: assert property (p_wait_power) else $error("left sleep unpowered");
endmodule // radio_core_sleep_wake_diag

// ---- verilog/sleep_wake_pkg.sv ----
package sleep_wake_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_HZ        = 50_000_000;
  localparam int SLOT_US       = 625;
  localparam int LP_HZ         = 32_000;
  // Split so the product stays below 2^31
  localparam int SLOT_CYCLES   = (REF_HZ / 1_000_000) * SLOT_US;
  localparam int SLOT_LP_TICKS = (LP_HZ * SLOT_US) / 1_000_000;
  localparam int SLOT_W        = 16;
  localparam int MEM_AW        = 16;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_WAKE_TIMING = 8'h00;
  localparam logic [7:0] REG_SLEEP_DUR   = 8'h04;
  localparam logic [7:0] REG_DS_CTRL     = 8'h08;
  localparam logic [7:0] REG_STATUS      = 8'h0C;
  localparam logic [7:0] REG_ACT_DUR     = 8'h10;
  localparam logic [7:0] REG_DIAG_A      = 8'h14;
  localparam logic [7:0] REG_DIAG_B      = 8'h18;
  localparam logic [7:0] REG_DIAG_C      = 8'h1C;
  localparam logic [7:0] REG_SLOT_CNT    = 8'h20;

  localparam int OFS_W        = 10;
  localparam int ASSERT_LSB   = 0;
  localparam int DEASSERT_LSB = 10;
  localparam int EXTW_LSB     = 20;

  localparam int CTL_SLEEP_REQ = 0;
  localparam int CTL_EXT_DIS   = 1;
  localparam int CTL_WAKE_REQ  = 2;
  localparam int CTL_CLK_EN    = 3;
  localparam int CTL_PWR_DN    = 4;

  localparam logic [31:0] CTRL_RST        = 32'h0000_0008;
  localparam logic [31:0] CTRL_REQ_MASK   = 32'h0000_0001;
  localparam logic [31:0] WAKE_TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] SLEEP_DUR_RST   = 32'h0000_0000;
  localparam logic [31:0] DIAG_SEL_RST    = 32'h0000_0000;

  localparam logic [31:0] DIAG_SCHEME_SIG  = 32'h8383_8383;
  localparam logic [31:0] DIAG_SCHEME_DATA = 32'h9292_9292;
  localparam logic [31:0] DIAG_ORDER_ID    = 32'h7654_3210;

  typedef enum logic [1:0] {ST_IDLE, ST_ENTER, ST_SLEEP, ST_EXPIRED} sleep_state_t;
endpackage

// ---- verilog/diag_if.sv ----
`timescale 1ns/10ps
interface diag_if;
  import sleep_wake_pkg::*;
  logic [31:0]       sel_a;
  logic [31:0]       sel_b;
  logic [31:0]       sel_c;
  logic              tx_en;
  logic              rx_en;
  logic              sync_window;
  logic              corr_success;
  logic              event_in_process;
  logic              rx_irq;
  logic              core_mem_req;
  logic              cpu_mem_req;
  logic [MEM_AW-1:0] core_mem_addr;
  logic [MEM_AW-1:0] cpu_mem_addr;
  logic [7:0]        data_sig;
  logic [7:0]        diag_out;

  modport mux (input sel_a, sel_b, sel_c, tx_en, rx_en, sync_window, corr_success, event_in_process, rx_irq,
               core_mem_req, cpu_mem_req, core_mem_addr, cpu_mem_addr, data_sig, output diag_out);
  modport host (output sel_a, sel_b, sel_c, tx_en, rx_en, sync_window, corr_success, event_in_process, rx_irq,
                core_mem_req, cpu_mem_req, core_mem_addr, cpu_mem_addr, data_sig, input diag_out);
endinterface // diag_if

// ---- verilog/sleep_wake_sync.sv ----
`timescale 1ns/10ps
module sleep_wake_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  // Level only moves once stages two and three agree
  wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire  [WIDTH-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
  assign rise  = lvl_d & ~lvl_q;

  property p_tick_single;
    @(posedge ref_clk) disable iff (srst) rise[0] |=> (level[0] && !rise[0]);
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("sleep clock tick not single");
endmodule // sleep_wake_sync

// ---- verilog/diag_mux.sv ----
`timescale 1ns/10ps
module diag_mux
  import sleep_wake_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  diag_if.mux      bus
);
  logic       evt_q;
  logic [7:0] out_q;

  // ---------------------------------------------------------------
  // Derived pulses
  // ---------------------------------------------------------------
  wire sync_found_g = bus.corr_success && bus.sync_window;
  wire event_irq    = evt_q && !bus.event_in_process;
  wire error_irq    = bus.core_mem_req && bus.cpu_mem_req &&
                      (bus.core_mem_addr == bus.cpu_mem_addr);

  // ---------------------------------------------------------------
  // Scheme selection
  // ---------------------------------------------------------------
  wire mode_sig  = (bus.sel_a == DIAG_SCHEME_SIG) && (bus.sel_b == DIAG_SCHEME_SIG);
  wire mode_data = (bus.sel_a == DIAG_SCHEME_DATA) && (bus.sel_b == DIAG_SCHEME_DATA);
  wire order_id  = (bus.sel_c == DIAG_ORDER_ID);
  wire [7:0] grp_sig = {error_irq, bus.rx_irq, event_irq, bus.event_in_process,
                        sync_found_g, bus.sync_window, bus.rx_en, bus.tx_en};
  // Undocumented selections drive zero
  wire [7:0] grp = mode_sig ? grp_sig : (mode_data ? bus.data_sig : 8'h00);

  // Nibble i of the third select picks the source of port i
  function automatic logic [7:0] reorder(input logic [7:0] g, input logic [31:0] c);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = g[c[4*i +: 3]];
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_q <= 1'b0;
      out_q <= 8'h00;
    end else begin
      evt_q <= bus.event_in_process;
      out_q <= reorder(grp, bus.sel_c);
    end
  end

  assign bus.diag_out = out_q;

  property p_sync_found_in_window;
    @(posedge ref_clk) disable iff (srst)
      (mode_sig && order_id && !bus.sync_window) |=> !bus.diag_out[3];
  endproperty
  a_sync_found_in_window: assert property (p_sync_found_in_window) else $error("sync found outside window");

  property p_event_end;
    @(posedge ref_clk) disable iff (srst)
      (mode_sig && order_id && $fell(bus.event_in_process)) |=> bus.diag_out[5];
  endproperty
  a_event_end: assert property (p_event_end) else $error("event end pulse missing");

  property p_mem_clash;
    @(posedge ref_clk) disable iff (srst) (mode_sig && order_id && error_irq) |=> bus.diag_out[7];
  endproperty
  a_mem_clash: assert property (p_mem_clash) else $error("memory clash pulse missing");

  property p_data_scheme;
    @(posedge ref_clk) disable iff (srst) (mode_data && order_id) |=> (bus.diag_out == $past(bus.data_sig));
  endproperty
  a_data_scheme: assert property (p_data_scheme) else $error("data scheme mismatch");
endmodule // diag_mux

// ---- sim/radio_core_sleep_wake_diag_tb.sv ----
`timescale 1ns/10ps
module radio_core_sleep_wake_diag_tb;
  import sleep_wake_pkg::*;
  logic        ref_clk, srst, reg_wr, reg_rd, sleep_clock, domain_up_flag;
  logic        clk_en, pd_out, pd_flag, wake_irq, exit_irq;
  logic [7:0]  reg_addr, sig, data_bits, diag_out;
  logic [15:0] ca, pa;
  logic [31:0] reg_wdata, reg_rdata, rv, sv;
  int          mismatches, cmp_count, xcnt, wseen;

  radio_core_sleep_wake_diag #(.SLOT_REF_CYCLES(16)) radio_core_sleep_wake_diag_inst (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_clock(sleep_clock), .domain_up_flag(domain_up_flag),
    .radio_clk_enable(clk_en), .baseband_power_down(pd_out), .powerdown_allowed_flag(pd_flag),
    .lp_wake_interrupt(wake_irq), .sleep_exit_interrupt(exit_irq), .radio_tx_en(sig[0]),
    .radio_rx_en(sig[1]), .sync_window(sig[2]), .corr_success(sig[3]), .event_in_process(sig[4]),
    .rx_packet_irq(sig[5]), .core_mem_req(sig[6]), .core_mem_addr(ca), .cpu_mem_req(sig[7]),
    .cpu_mem_addr(pa), .data_bits(data_bits), .diag_out(diag_out));

  initial begin ref_clk = 0; forever #10 ref_clk = ~ref_clk; end
  // Slightly off 32 kHz; every tenth of its edges still lands on a ref_clk edge
  initial begin sleep_clock = 0; forever #15617 sleep_clock = ~sleep_clock; end
  always @(posedge ref_clk) begin
    if (exit_irq === 1'b1) xcnt++;
    if (wake_irq === 1'b1) wseen++;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task dg(input logic [7:0] s, input logic [7:0] e);
    @(posedge ref_clk);
    sig <= s;
    @(posedge ref_clk);
    #1 chk("diag_out", {24'h0, e}, {24'h0, diag_out});
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    rd(REG_DS_CTRL);
    chk("ctrl", CTRL_RST, rv);
    rd(8'h3C);
    chk("unmapped", 32'h0, rv);
    chk("clk_en_rst", 1, clk_en);
    chk("pwr_dn_rst", 0, pd_out);
    rd(REG_SLOT_CNT);
    sv = rv;
    repeat (30) @(posedge ref_clk);
    // Samples 32 cycles apart: two slots of 16 cycles each
    rd(REG_SLOT_CNT);
    chk("slot_rate", 32'h0000_0002, rv - sv);
    $display("test reset done");
  endtask
  task t_diag;
    wr(REG_DIAG_A, DIAG_SCHEME_SIG);
    wr(REG_DIAG_B, DIAG_SCHEME_SIG);
    wr(REG_DIAG_C, DIAG_ORDER_ID);
    dg(8'h01, 8'h01);
    dg(8'h02, 8'h02);
    dg(8'h08, 8'h00);
    dg(8'h0C, 8'h0C);
    dg(8'h20, 8'h40);
    dg(8'hC0, 8'h80);
    @(posedge ref_clk) pa <= 16'h0001;
    dg(8'hC0, 8'h00);
    dg(8'h10, 8'h10);
    @(posedge ref_clk) sig <= 8'h00;
    rv = 0;
    repeat (3) begin @(posedge ref_clk); #1 rv += diag_out[5]; end
    chk("event_pulse", 1, rv);
    wr(REG_DIAG_A, DIAG_SCHEME_DATA);
    wr(REG_DIAG_B, DIAG_SCHEME_DATA);
    data_bits <= 8'hA5;
    dg(8'h00, 8'hA5);
    $display("test diag done");
  endtask
  task t_timed;
    wr(REG_WAKE_TIMING, 32'h0020_0402);
    wr(REG_SLEEP_DUR, 32'd4);
    wr(REG_DS_CTRL, 32'h9);
    for (int i = 0; i < 4000 && pd_flag !== 1'b1; i++) @(posedge ref_clk);
    chk("pd_flag", 1, pd_flag);
    wr(REG_DS_CTRL, 32'h11);
    #1 chk("clk_gated", 0, clk_en);
    chk("pwr_dn", 1, pd_out);
    wseen = 0;
    xcnt = 0;
    repeat (12500) @(posedge ref_clk);
    chk("early_exit", 0, xcnt);
    chk("wake_len", 1, wseen > 1000 && wseen < 2200);
    rd(REG_STATUS);
    chk("expired", 2'b11, {rv[4], rv[0]});
    @(posedge ref_clk) domain_up_flag <= 1'b1;
    // Powered but clocks still gated: exit must wait
    repeat (40) @(posedge ref_clk);
    chk("clk_off_hold", 0, xcnt);
    wr(REG_DS_CTRL, 32'h9);
    for (int i = 0; i < 40 && xcnt == 0; i++) @(posedge ref_clk);
    #1 chk("exit", 1, xcnt);
    rd(REG_ACT_DUR);
    chk("act_dur", 1, rv > 32'd4);
    chk("pd_after", 0, pd_flag);
    $display("test timed wake done");
  endtask
  task t_ext;
    wr(REG_DS_CTRL, 32'hD);
    repeat (4000) @(posedge ref_clk);
    chk("refused", 0, pd_flag);
    wr(REG_DS_CTRL, 32'h8);
    wr(REG_SLEEP_DUR, 32'd100);
    wr(REG_DS_CTRL, 32'hB);
    for (int i = 0; i < 4000 && pd_flag !== 1'b1; i++) @(posedge ref_clk);
    wseen = 0;
    wr(REG_DS_CTRL, 32'hF);
    repeat (5) @(posedge ref_clk);
    chk("wake_disabled", 0, wseen);
    wr(REG_DS_CTRL, 32'h9);
    xcnt = 0;
    wr(REG_DS_CTRL, 32'hD);
    for (int i = 0; i < 3 && wake_irq !== 1'b1; i++) @(posedge ref_clk);
    #1 chk("wake_now", 1, wake_irq);
    for (int i = 0; i < 6000 && xcnt == 0; i++) @(posedge ref_clk);
    #1 chk("ext_exit", 1, xcnt);
    wr(REG_DS_CTRL, 32'h8);
    $display("test external wake done");
  endtask

  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, domain_up_flag, sig, data_bits} = '0;
    srst = 1'b1;
    ca = 16'h1234;
    pa = 16'h1234;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_diag;
    t_timed;
    t_ext;
    test_done;
  end
  initial begin
    #1_500_000;
    chk("watchdog", 0, 1);
    test_done;
  end
endmodule // radio_core_sleep_wake_diag_tb
